// ==== bcxm_checker.sv ====
// Purpose: Port assertions for the channel crosspoint.
// Assumes: Bound to every bcxm_crosspoint instance.
// Notes: One clock domain.
`timescale 1ns/1ps
module bcxm_checker #(
  parameter int unsigned FRAME_CYCLES = 20
) (
  input wire logic clk_sys, // Clock.
  input wire logic arst_n, // Reset, active low.
  input wire logic s_axi_arvalid, // Read address valid.
  input wire logic s_axi_arready, // Read address ready.
  input wire logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic s_axi_rvalid, // Read valid.
  input wire logic [7:0][7:0] ch_rx_data, // Delivered bytes.
  input wire logic [7:0] ch_rx_routed, // Routed flags.
  input wire logic frame_strobe // Frame boundary.
);
  logic [31:0] cnt_q;
  logic seen_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // The first frame after reset is one cycle longer than the rest.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      seen_q <= 1'b0;
    end else begin
      cnt_q <= frame_strobe ? 32'h1 : cnt_q + 32'h1;
      seen_q <= seen_q | frame_strobe;
    end
  end
  strobe_width_a: assert property (frame_strobe |=> !frame_strobe)
    else $error("strobe too wide");
  frame_period_a: assert property (
    frame_strobe |-> cnt_q == FRAME_CYCLES + 32'(!seen_q))
    else $error("frame period wrong");
  strobe_due_a: assert property (cnt_q <= FRAME_CYCLES + 1)
    else $error("strobe missing");
  rx_hold_a: assert property (!frame_strobe |->
    $stable(ch_rx_data) && $stable(ch_rx_routed)) else $error("rx moved");
  for (genvar i = 0; i < 8; i++) begin : g_idle
    idle_byte_a: assert property (
      !ch_rx_routed[i] |-> ch_rx_data[i] == 8'hff) else $error("idle byte");
  end
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready in read");
  write_done_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
endmodule : bcxm_checker

bind bcxm_crosspoint bcxm_checker #(.FRAME_CYCLES(FRAME_CYCLES)) i_chk (
  .clk_sys, .arst_n, .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .ch_rx_data, .ch_rx_routed, .frame_strobe);

// ==== bcxm_crosspoint.sv ====
// Purpose: Crosspoint that routes eight 64 kbit/s full-duplex channels.
// Assumes: Channel bytes come from logic on clk_sys; AXI4-Lite register bus.
// Notes: Port index i carries channel code i+1; one byte per port per frame.
//
// Summary of operation
// - Every uncontested routed channel moves full duplex at 64 kbit/s between units.
// - Three bidirectional paths join any three ports to three others.
// - Path register bits 7-4 name endpoint one, bits 3-0 endpoint two.
// - Codes: 0 none, 1-2 line, 3 audio, 4-5 host, 6-8 peripheral.
// - Equal codes in both fields loop a channel back onto itself.
// - Path register c beats b, and b beats a.
// - Contested destination takes the winning path; other directions stay.
// - Order register bit 3 enables the host byte interrupt, status bit 4.
// - Order register bit 4 makes host channel zero LSB first.
// - Order register bit 5 makes host channel one LSB first.
`timescale 1ns/1ps
`include "bcxm_map.svh"
module bcxm_crosspoint #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned FRAME_CYCLES = `BCXM_FRAME_CYCLES
) (
  input wire logic clk_sys, // System clock, 200 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic [7:0][7:0] ch_tx_data, // Byte offered by each port.
  output logic [7:0][7:0] ch_rx_data, // Byte delivered to each port.
  output logic [7:0] ch_rx_routed, // Port received a routed byte.
  output logic frame_strobe, // One-cycle pulse at each frame boundary.
  output logic irq // Level interrupt, high while enabled status is set.
);

  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_idx;
    logic w_have;
    logic [7:0] w_byte;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    bcxm_pkg::bcxm_path_t [2:0] path;
    logic [7:0] order;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [7:0][7:0] rx;
    logic [7:0] routed;
    logic [7:0] frames;
    logic frame;
    logic irq;
  } bcxm_state_t;

  bcxm_state_t s_q;
  bcxm_state_t s_d;
  logic tick;

  bcxm_frame_timer #(
    .FRAME_CYCLES(FRAME_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .tick_q(tick)
  );

  // Word number of a byte address; registers sit one per aligned word.
  function automatic logic [7:0] bcxm_word(input logic [ADDR_W-1:0] a);
    bcxm_word = a[9:2];
  endfunction : bcxm_word

  function automatic logic bcxm_code_ok(input logic [3:0] c);
    bcxm_code_ok = (c >= `BCXM_CODE_FIRST) && (c <= `BCXM_CODE_LAST);
  endfunction : bcxm_code_ok

  function automatic logic [2:0] bcxm_port(input logic [3:0] c);
    logic [3:0] t;
    t = c - `BCXM_CODE_FIRST;
    bcxm_port = t[2:0];
  endfunction : bcxm_port

  function automatic logic [7:0] bcxm_rev(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    bcxm_rev = r;
  endfunction : bcxm_rev

  // Returns {contested, found, source port} for destination port d.
  function automatic logic [4:0] bcxm_pick(
    input bcxm_pkg::bcxm_path_t [2:0] p,
    input logic [2:0] d
  );
    logic [3:0] me;
    logic found;
    logic multi;
    logic [2:0] src;
    me = {1'b0, d} + `BCXM_CODE_FIRST;
    found = 1'b0;
    multi = 1'b0;
    src = 3'h0;
    // Later paths overwrite earlier ones, so c wins over b over a.
    for (int k = 0; k < 3; k++) begin
      if (bcxm_code_ok(p[k].ep1) && bcxm_code_ok(p[k].ep2)) begin
        if (p[k].ep2 == me) begin
          multi = found;
          found = 1'b1;
          src = bcxm_port(p[k].ep1);
        end else if (p[k].ep1 == me) begin
          multi = found;
          found = 1'b1;
          src = bcxm_port(p[k].ep2);
        end
      end
    end
    bcxm_pick = {multi, found, src};
  endfunction : bcxm_pick

  function automatic logic bcxm_rev_en(
    input logic [7:0] ord,
    input logic [2:0] port
  );
    logic r;
    r = 1'b0;
    if (port == `BCXM_IDX_HOST0) begin
      r = ord[`BCXM_ORDER_REV0_BIT];
    end else if (port == `BCXM_IDX_HOST1) begin
      r = ord[`BCXM_ORDER_REV1_BIT];
    end
    bcxm_rev_en = r;
  endfunction : bcxm_rev_en

  always_comb begin
    logic [4:0] pk;
    logic [7:0] b;
    logic [7:0] set;
    logic [7:0] clr;
    logic [7:0] widx;
    logic [7:0] ridx;
    pk = 5'h00;
    b = 8'h00;
    set = 8'h00;
    clr = 8'h00;
    widx = 8'h00;
    ridx = 8'h00;
    s_d = s_q;
    s_d.frame = 1'b0;

    // Write channel: address and data are taken in either order.
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_idx = bcxm_word(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.w_byte = s_axi_wdata[7:0];
      s_d.w_lane0 = s_axi_wstrb[0];
    end
    if (s_d.aw_have && s_d.w_have && !s_d.bvalid) begin
      widx = s_d.aw_idx;
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `BCXM_RESP_OKAY;
      unique case (widx)
        `BCXM_IDX_PATH_A: begin
          if (s_d.w_lane0) begin
            s_d.path[0] = s_d.w_byte;
          end
        end
        `BCXM_IDX_PATH_B: begin
          if (s_d.w_lane0) begin
            s_d.path[1] = s_d.w_byte;
          end
        end
        `BCXM_IDX_PATH_C: begin
          if (s_d.w_lane0) begin
            s_d.path[2] = s_d.w_byte;
          end
        end
        `BCXM_IDX_ORDER: begin
          if (s_d.w_lane0) begin
            // Reserved positions are not stored and read back as zero.
            s_d.order = s_d.w_byte & `BCXM_ORDER_WR_MASK;
          end
        end
        `BCXM_IDX_IRQ_STAT: begin
          if (s_d.w_lane0) begin
            clr = s_d.w_byte & `BCXM_IRQ_WR_MASK;
          end
        end
        `BCXM_IDX_IRQ_MASK: begin
          if (s_d.w_lane0) begin
            s_d.irq_mask = s_d.w_byte & `BCXM_IRQ_WR_MASK;
          end
        end
        `BCXM_IDX_ROUTED, `BCXM_IDX_FRAMES: begin
          s_d.bresp = `BCXM_RESP_OKAY;
        end
        default: begin
          s_d.bresp = `BCXM_RESP_SLVERR;
        end
      endcase
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready = !s_d.w_have && !s_d.bvalid;

    // Read channel: one read at a time, data one cycle after the address.
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      ridx = bcxm_word(s_axi_araddr);
      s_d.rvalid = 1'b1;
      s_d.rresp = `BCXM_RESP_OKAY;
      s_d.rdata = 32'h0;
      unique case (ridx)
        `BCXM_IDX_PATH_A: begin
          s_d.rdata[7:0] = s_q.path[0];
        end
        `BCXM_IDX_PATH_B: begin
          s_d.rdata[7:0] = s_q.path[1];
        end
        `BCXM_IDX_PATH_C: begin
          s_d.rdata[7:0] = s_q.path[2];
        end
        `BCXM_IDX_ORDER: begin
          s_d.rdata[7:0] = s_q.order;
        end
        `BCXM_IDX_IRQ_STAT: begin
          s_d.rdata[7:0] = s_q.irq_stat;
        end
        `BCXM_IDX_IRQ_MASK: begin
          s_d.rdata[7:0] = s_q.irq_mask;
        end
        `BCXM_IDX_ROUTED: begin
          s_d.rdata[7:0] = s_q.routed;
        end
        `BCXM_IDX_FRAMES: begin
          s_d.rdata[7:0] = s_q.frames;
        end
        default: begin
          s_d.rresp = `BCXM_RESP_SLVERR;
        end
      endcase
    end
    s_d.arready = !s_d.rvalid;

    // Frame boundary: sample every port and deliver through the live paths.
    // Path and bit-order writes land between boundaries and act at the next one.
    if (tick) begin
      s_d.frame = 1'b1;
      s_d.frames = s_q.frames + 8'h01;
      set[`BCXM_IRQ_FRAME_BIT] = 1'b1;
      for (int d = 0; d < 8; d++) begin
        pk = bcxm_pick(s_q.path, 3'(d));
        b = ch_tx_data[pk[2:0]];
        if (bcxm_rev_en(s_q.order, pk[2:0])) begin
          b = bcxm_rev(b);
        end
        if (bcxm_rev_en(s_q.order, 3'(d))) begin
          b = bcxm_rev(b);
        end
        if (pk[3]) begin
          s_d.rx[d] = b;
        end else begin
          s_d.rx[d] = `BCXM_IDLE_BYTE;
        end
        s_d.routed[d] = pk[3];
        if (pk[4]) begin
          set[`BCXM_IRQ_CONFLICT_BIT] = 1'b1;
        end
        if (pk[3] && ((3'(d) == `BCXM_IDX_HOST0) ||
            (3'(d) == `BCXM_IDX_HOST1))) begin
          set[`BCXM_IRQ_HOST_BIT] = 1'b1;
        end
      end
    end

    // A new event wins over a clear written in the same cycle.
    s_d.irq_stat = (s_q.irq_stat & ~clr) | set;
    s_d.irq = (s_d.irq_stat[`BCXM_IRQ_HOST_BIT] &
               s_d.irq_mask[`BCXM_IRQ_HOST_BIT] &
               s_d.order[`BCXM_ORDER_IRQ_EN_BIT]) |
              (s_d.irq_stat[`BCXM_IRQ_CONFLICT_BIT] &
               s_d.irq_mask[`BCXM_IRQ_CONFLICT_BIT]) |
              (s_d.irq_stat[`BCXM_IRQ_FRAME_BIT] &
               s_d.irq_mask[`BCXM_IRQ_FRAME_BIT]);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.path <= {3{`BCXM_PATH_RESET}};
      s_q.order <= `BCXM_ORDER_RESET;
      s_q.irq_stat <= `BCXM_IRQ_STAT_RESET;
      s_q.irq_mask <= `BCXM_IRQ_MASK_RESET;
      s_q.rx <= {8{`BCXM_IDLE_BYTE}};
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign ch_rx_data = s_q.rx;
  assign ch_rx_routed = s_q.routed;
  assign frame_strobe = s_q.frame;
  assign irq = s_q.irq;

endmodule : bcxm_crosspoint

// ==== bcxm_crosspoint_test.sv ====
// Purpose: Self-checking bench for the channel crosspoint.
// Assumes: Frame shortened to 20 cycles.
// Notes: Routing is predicted by a bench model.
`timescale 1ns/1ps
module bcxm_crosspoint_test;
  localparam int unsigned FRAMES = 20;
  logic clk_sys, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, irq;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, frame_strobe;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0][7:0] ch_tx_data, ch_rx_data, fill;
  logic [7:0] ch_rx_routed, d, od;
  logic [23:0] p;
  logic [71:0] e;
  int n_fail, comparisons, cyc;
  bcxm_crosspoint #(.FRAME_CYCLES(FRAMES)) i_dut (.clk_sys, .arst_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ch_tx_data, .ch_rx_data, .ch_rx_routed,
    .frame_strobe, .irq);
  bcxm_far_units i_far (.clk_sys, .arst_n, .frame_strobe, .fill,
    .ch_tx_data);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [7:0] rv(logic [7:0] b, int i, logic [7:0] o);
    logic [7:0] y;
    y = b;
    if (i == 3 && o[4] || i == 4 && o[5]) y = {<<{b}};
    return y;
  endfunction : rv
  // Later paths overwrite earlier ones; host bytes flip on both sides.
  function automatic logic [71:0] mdl(logic [23:0] m, logic [7:0] o,
      logic [7:0][7:0] t);
    logic [7:0][7:0] r;
    logic [7:0] ro;
    int a;
    int b;
    r = '1;
    ro = '0;
    for (int k = 0; k < 3; k++) begin
      a = m[8*k+4 +: 4];
      b = m[8*k +: 4];
      if (a inside {[1:8]} && b inside {[1:8]}) begin
        r[b-1] = rv(t[a-1], a - 1, o);
        r[a-1] = rv(t[b-1], b - 1, o);
        ro[a-1] = 1'b1;
        ro[b-1] = 1'b1;
      end
    end
    r[3] = rv(r[3], 3, o);
    r[4] = rv(r[4], 4, o);
    return {ro, r};
  endfunction : mdl
  task automatic chk(logic [71:0] seen, logic [71:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(logic [7:0] i, logic [7:0] v);
    @(posedge clk_sys);
    s_axi_awaddr <= {2'b00, i, 2'b00};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] i);
    @(posedge clk_sys);
    s_axi_araddr <= {2'b00, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata[7:0];
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic ws();
    do @(negedge clk_sys); while (frame_strobe !== 1'b1);
  endtask : ws
  task automatic give_verdict();
    $display("n_fail %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, arst_n} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    fill = '0;
    seed = 32'h5a;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(8'h46 - 8'(i));
      chk(d, i == 0 ? 8'h13 : 8'h00);
    end
    rd(8'h00);
    chk(rsp, 2'h2);
    wr(8'h00, 8'h5a);
    chk(rsp, 2'h2);
    wr(8'h44, 8'h38);
    rd(8'h44);
    chk(d, 8'h38);
    // A write without lane zero is answered but stores nothing.
    s_axi_wstrb <= 4'he;
    wr(8'h44, 8'h00);
    chk(rsp, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(8'h44);
    chk(d, 8'h38);
    // Reserved order bits are always written as zero.
    for (int n = 0; n < 13; n++) begin
      seed = xs(seed);
      p = seed[23:0];
      od = seed[31:24] & 8'h38;
      if (n == 0) p = 24'h431400;
      if (n == 1) p = 24'h332211;
      if (n == 2) p = 24'h554491;
      if (n == 3) p = 24'h005241;
      fill <= {xs(seed), seed};
      wr(8'h41, p[7:0]);
      wr(8'h42, p[15:8]);
      wr(8'h43, p[23:16]);
      wr(8'h44, od);
      rd(8'h43);
      chk(d, p[23:16]);
      ws();
      ws();
      e = mdl(p, od, ch_tx_data);
      chk({ch_rx_routed, ch_rx_data}, e);
      rd(8'h47);
      chk(d, e[71:64]);
    end
    // The first corner case claims host channel zero twice: sticky conflict.
    rd(8'h45);
    chk(d[1:0], 2'h3);
    wr(8'h46, 8'h10);
    wr(8'h41, 8'h41);
    wr(8'h42, 8'h00);
    wr(8'h43, 8'h00);
    wr(8'h44, 8'h00);
    ws();
    ws();
    repeat (2) @(negedge clk_sys);
    chk(irq, 1'b0);
    wr(8'h44, 8'h08);
    ws();
    repeat (2) @(negedge clk_sys);
    chk(irq, 1'b1);
    rd(8'h45);
    chk(d[4], 1'b1);
    wr(8'h45, 8'h10);
    repeat (2) @(negedge clk_sys);
    chk(irq, 1'b0);
    wr(8'h46, 8'h00);
    ws();
    repeat (2) @(negedge clk_sys);
    chk(irq, 1'b0);
    give_verdict();
  end
endmodule : bcxm_crosspoint_test

// ==== bcxm_far_units.sv ====
// Purpose: Far units that offer one byte per channel port.
// Assumes: Frames are marked by the crosspoint strobe.
// Notes: New bytes are taken only at a frame boundary.
`timescale 1ns/1ps
module bcxm_far_units (
  input wire logic clk_sys, // Clock.
  input wire logic arst_n, // Reset, active low.
  input wire logic frame_strobe, // Frame boundary.
  input wire logic [7:0][7:0] fill, // Next bytes to offer.
  output logic [7:0][7:0] ch_tx_data // Bytes offered.
);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) ch_tx_data <= '0;
    else if (frame_strobe) ch_tx_data <= fill;
  end
endmodule : bcxm_far_units

// ==== bcxm_frame_timer.sv ====
// Purpose: Frame boundary strobe for the channel crosspoint.
// Assumes: FRAME_CYCLES is at least two.
// Notes: The strobe is one cycle wide, once per frame period.
`timescale 1ns/1ps
`include "bcxm_map.svh"
module bcxm_frame_timer #(
  parameter int unsigned FRAME_CYCLES = `BCXM_FRAME_CYCLES
) (
  input wire logic clk_sys, // System clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  output logic tick_q // One-cycle frame strobe.
);

  bcxm_pkg::bcxm_timer_t s_q;
  bcxm_pkg::bcxm_timer_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 32'(FRAME_CYCLES - 1)) begin
      s_d.cnt = 32'h0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_q = s_q.tick;

endmodule : bcxm_frame_timer

// ==== bcxm_map.svh ====
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Included by its bare name wherever these values are needed.
// Notes: Register indices are word numbers; byte address is four times.
`ifndef BCXM_MAP_SVH
`define BCXM_MAP_SVH

`define BCXM_IDX_PATH_A 8'h41
`define BCXM_IDX_PATH_B 8'h42
`define BCXM_IDX_PATH_C 8'h43
`define BCXM_IDX_ORDER 8'h44
`define BCXM_IDX_IRQ_STAT 8'h45
`define BCXM_IDX_IRQ_MASK 8'h46
`define BCXM_IDX_ROUTED 8'h47
`define BCXM_IDX_FRAMES 8'h48

`define BCXM_PATH_RESET 8'h00
`define BCXM_ORDER_RESET 8'h00
`define BCXM_IRQ_STAT_RESET 8'h00
`define BCXM_IRQ_MASK_RESET 8'h13

`define BCXM_ORDER_IRQ_EN_BIT 3
`define BCXM_ORDER_REV0_BIT 4
`define BCXM_ORDER_REV1_BIT 5
`define BCXM_ORDER_WR_MASK 8'h38

`define BCXM_IRQ_CONFLICT_BIT 0
`define BCXM_IRQ_FRAME_BIT 1
`define BCXM_IRQ_HOST_BIT 4
`define BCXM_IRQ_WR_MASK 8'h13

`define BCXM_CODE_NONE 4'h0
`define BCXM_CODE_FIRST 4'h1
`define BCXM_CODE_LAST 4'h8
`define BCXM_IDX_HOST0 3'h3
`define BCXM_IDX_HOST1 3'h4

`define BCXM_IDLE_BYTE 8'hff

`define BCXM_RESP_OKAY 2'h0
`define BCXM_RESP_SLVERR 2'h2

`define BCXM_FRAME_NS 125000
`define BCXM_CLK_PERIOD_PS 5000
`define BCXM_FRAME_CYCLES ((`BCXM_FRAME_NS * 1000) / `BCXM_CLK_PERIOD_PS)

`endif

// ==== bcxm_pkg.sv ====
// Purpose: Shared types of the channel crosspoint.
// Assumes: Numeric values live in bcxm_map.svh.
// Notes: One path register is two four-bit channel codes.
package bcxm_pkg;

  typedef struct packed {
    logic [3:0] ep1;
    logic [3:0] ep2;
  } bcxm_path_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } bcxm_timer_t;

endpackage : bcxm_pkg
